// file: hw/i2sts_pkg.sv
/*
 * Shared constants of the two-wire status and transmit-lock block:
 * register offsets, field positions and reset values.
 * Assumes a 32-bit classic Wishbone slave port, byte addresses.
 */
package i2sts_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STAT_OFS   = 8'h04;
    localparam logic [7:0] FLAGS_OFS  = 8'h08;
    localparam logic [7:0] DATA_OFS   = 8'h0C;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTRL_MST_BIT  = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_RXE_BIT  = 1;
    localparam int STAT_RXF_BIT  = 2;
    localparam int STAT_TXE_BIT  = 3;
    localparam int STAT_TXF_BIT  = 4;
    localparam int STAT_CKMD_BIT = 5;
    localparam int FLAG_LOCK_BIT = 15;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic       CTRL_MST_RST  = 1'h0;
    localparam logic       FLAG_LOCK_RST = 1'h0;

endpackage

// file: hw/i2sts_core.sv
/*
 * Status reporting and transmit-FIFO lock of a two-wire bus controller.
 * Holds a small TX and RX FIFO, a START/STOP watcher on the link clock
 * and a classic Wishbone register slave on core_clk.
 * Assumes the bit engine sits on core_clk and pops TX / pushes RX
 * through the engine ports; SCL and SDA arrive as plain pin levels.
 * Reset leaves asynchronously; hold it over a few link_clk edges.
 */
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/10ps

// Summary of operation
// [RQ1] Clock-drive bit reads 1 from our master START until STOP; the code also counts an outside START while mst is set.
// [RQ2] Clock-drive bit stays 1 while a target stretches the clock.
// [RQ3] TX full bit is 1 exactly when TX FIFO holds depth entries.
// [RQ4] TX empty bit is 1 exactly when TX FIFO holds nothing.
// [RQ5] RX full bit is 1 exactly when RX FIFO holds depth entries.
// [RQ6] RX empty bit is 1 exactly when RX FIFO holds nothing.
// [RQ7] Busy bit is 1 from any START until STOP, either role.
// [RQ8] While lock flag is set, software TX FIFO writes are dropped.
// [RQ9] Setting the lock flag flushes the TX FIFO.
// [RQ10] Writing 1 clears the lock flag; writing 0 leaves it alone.
// [RQ11] Software keeps reserved upper bits unchanged when writing.
// [RQ12] Software picks master role with control bit 1, target with 0.
// [RQ13] Status bits ignore writes and show only live state.
module i2sts_core #(
    parameter int DEPTH = 8,
    parameter int DW    = 8
) (
    // Core clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    // Link clock and bus pin levels
    input  wire logic                 link_clk,
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    // Wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // Bit engine side
    input  wire logic                 tx_pop,
    output logic      [DW-1:0]        tx_byte,
    input  wire logic                 rx_push,
    input  wire logic [DW-1:0]        rx_byte,
    input  wire logic                 lock_set
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // Count needs one more bit than the pointers to tell full from empty
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    function automatic logic is_full(input logic [CW-1:0] c);
        is_full = (c == FULL_CNT);
    endfunction

    function automatic logic is_empty(input logic [CW-1:0] c);
        is_empty = (c == '0);
    endfunction

    // ****************************************************************
    // Link domain: pin synchronisers and START/STOP watcher
    // ****************************************************************
    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic sda_s1;
        logic sda_s2;
        logic scl_d;
        logic sda_d;
        logic busy;
    } i2sts_link_t;

    i2sts_link_t link_reg;
    i2sts_link_t link_next;

    always_comb
    begin
        link_next        = link_reg;
        link_next.scl_s1 = scl_in;
        link_next.scl_s2 = link_reg.scl_s1;
        link_next.sda_s1 = sda_in;
        link_next.sda_s2 = link_reg.sda_s1;
        link_next.scl_d  = link_reg.scl_s2;
        link_next.sda_d  = link_reg.sda_s2;
        // START: SDA falls with SCL high; STOP: SDA rises with SCL high.
        // Clock stretching only holds SCL low, so busy is untouched.
        if (link_reg.scl_s2 && link_reg.scl_d
            && link_reg.sda_d && !link_reg.sda_s2)
        begin
            link_next.busy = 1'b1; // [RQ7]
        end
        else if (link_reg.scl_s2 && link_reg.scl_d
                 && !link_reg.sda_d && link_reg.sda_s2)
        begin
            link_next.busy = 1'b0; // [RQ7]
        end
    end

    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // Pins idle high, so synchronisers reset high: no false START
            link_reg <= '{scl_s1: 1'b1, scl_s2: 1'b1, sda_s1: 1'b1,
                          sda_s2: 1'b1, scl_d: 1'b1, sda_d: 1'b1,
                          busy: 1'b0};
        end
        else
        begin
            link_reg <= link_next;
        end
    end

    // ****************************************************************
    // Core domain state
    // ****************************************************************
    typedef struct packed {
        logic                      busy_s1;
        logic                      busy_s2;
        logic                      mst;
        logic                      lock;
        logic [DEPTH-1:0][DW-1:0]  tx_mem;
        logic [AW-1:0]             tx_wr;
        logic [AW-1:0]             tx_rd;
        logic [CW-1:0]             tx_cnt;
        logic [DEPTH-1:0][DW-1:0]  rx_mem;
        logic [AW-1:0]             rx_wr;
        logic [AW-1:0]             rx_rd;
        logic [CW-1:0]             rx_cnt;
        logic [DW-1:0]             tx_out;
        logic                      ack;
        logic [31:0]               dat;
    } i2sts_core_t;

    i2sts_core_t core_reg;
    i2sts_core_t core_next;

    logic        acc;
    logic        wr;
    logic        rd;
    logic        tx_push_ok;
    logic        tx_pop_ok;
    logic        rx_push_ok;
    logic        rx_pop_ok;
    logic [31:0] stat_word;

    always_comb
    begin
        core_next         = core_reg;
        // Busy is a single level bit from the link domain; two flops
        // suffice since it changes only at START and STOP
        core_next.busy_s1 = link_reg.busy;
        core_next.busy_s2 = core_reg.busy_s1;

        // Single-cycle answer; ack drops the cycle after it rises
        // Writes land at the edge that raises ack; the master holds on
        acc = wb_cyc_i && wb_stb_i && !core_reg.ack;
        wr  = acc && wb_we_i;
        rd  = acc && !wb_we_i;
        core_next.ack = acc;

        // Status is built from live state only; writes never reach it
        stat_word = '0; // [RQ13]
        stat_word[i2sts_pkg::STAT_BUSY_BIT] = core_reg.busy_s2; // [RQ7]
        stat_word[i2sts_pkg::STAT_RXE_BIT]  =
            is_empty(core_reg.rx_cnt); // [RQ6]
        stat_word[i2sts_pkg::STAT_RXF_BIT]  =
            is_full(core_reg.rx_cnt); // [RQ5]
        stat_word[i2sts_pkg::STAT_TXE_BIT]  =
            is_empty(core_reg.tx_cnt); // [RQ4]
        stat_word[i2sts_pkg::STAT_TXF_BIT]  =
            is_full(core_reg.tx_cnt); // [RQ3]
        // Holds through stretching since only STOP ends busy.
        // Limitation: a START by an outside master also counts here
        // while the role bit selects master.
        stat_word[i2sts_pkg::STAT_CKMD_BIT] =
            core_reg.busy_s2 && core_reg.mst; // [RQ1] [RQ2]

        // Lock: hardware set wins over a software clear in the same cycle
        if (lock_set)
        begin
            core_next.lock = 1'b1;
        end
        else if (wr && wb_adr_i == i2sts_pkg::FLAGS_OFS && wb_sel_i[1]
                 && wb_dat_i[i2sts_pkg::FLAG_LOCK_BIT])
        begin
            core_next.lock = 1'b0; // [RQ10]
        end

        if (wr && wb_adr_i == i2sts_pkg::CTRL_OFS && wb_sel_i[0])
        begin
            core_next.mst = wb_dat_i[i2sts_pkg::CTRL_MST_BIT]; // [RQ12]
        end

        // TX FIFO; a write in the locking cycle is also dropped
        // Flush wins over push and pop in the locking cycle
        tx_push_ok = wr && wb_adr_i == i2sts_pkg::DATA_OFS && wb_sel_i[0]
                     && !core_reg.lock && !lock_set
                     && !is_full(core_reg.tx_cnt); // [RQ8]
        tx_pop_ok  = tx_pop && !is_empty(core_reg.tx_cnt);
        if (lock_set)
        begin
            core_next.tx_wr  = '0; // [RQ9]
            core_next.tx_rd  = '0;
            core_next.tx_cnt = '0;
        end
        else
        begin
            if (tx_push_ok)
            begin
                core_next.tx_mem[core_reg.tx_wr] = wb_dat_i[DW-1:0];
                core_next.tx_wr = ptr_inc(core_reg.tx_wr);
            end
            if (tx_pop_ok)
            begin
                core_next.tx_out = core_reg.tx_mem[core_reg.tx_rd];
                core_next.tx_rd  = ptr_inc(core_reg.tx_rd);
            end
            if (tx_push_ok && !tx_pop_ok)
            begin
                core_next.tx_cnt = CW'(core_reg.tx_cnt + 1'b1);
            end
            else if (tx_pop_ok && !tx_push_ok)
            begin
                core_next.tx_cnt = CW'(core_reg.tx_cnt - 1'b1);
            end
        end

        // RX FIFO: engine pushes, software read of the data word pops
        // A byte pushed into a full RX FIFO is lost; software must keep up
        rx_push_ok = rx_push && !is_full(core_reg.rx_cnt);
        rx_pop_ok  = rd && wb_adr_i == i2sts_pkg::DATA_OFS
                     && !is_empty(core_reg.rx_cnt);
        if (rx_push_ok)
        begin
            core_next.rx_mem[core_reg.rx_wr] = rx_byte;
            core_next.rx_wr = ptr_inc(core_reg.rx_wr);
        end
        if (rx_pop_ok)
        begin
            core_next.rx_rd = ptr_inc(core_reg.rx_rd);
        end
        if (rx_push_ok && !rx_pop_ok)
        begin
            core_next.rx_cnt = CW'(core_reg.rx_cnt + 1'b1);
        end
        else if (rx_pop_ok && !rx_push_ok)
        begin
            core_next.rx_cnt = CW'(core_reg.rx_cnt - 1'b1);
        end

        // Read mux; unmapped offsets answer with zero
        // Reading the data word pops RX, so a stray read loses a byte
        core_next.dat = '0;
        if (rd)
        begin
            case (wb_adr_i)
                i2sts_pkg::CTRL_OFS:
                    core_next.dat[i2sts_pkg::CTRL_MST_BIT] = core_reg.mst;
                i2sts_pkg::STAT_OFS:
                    core_next.dat = stat_word;
                i2sts_pkg::FLAGS_OFS:
                    core_next.dat[i2sts_pkg::FLAG_LOCK_BIT] = core_reg.lock;
                i2sts_pkg::DATA_OFS:
                    if (core_reg.rx_cnt != '0)
                    begin
                        core_next.dat[DW-1:0] =
                            core_reg.rx_mem[core_reg.rx_rd];
                    end
                default:
                    core_next.dat = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            core_reg      <= '0;
            core_reg.mst  <= i2sts_pkg::CTRL_MST_RST;
            core_reg.lock <= i2sts_pkg::FLAG_LOCK_RST;
        end
        else
        begin
            core_reg <= core_next;
        end
    end

    assign wb_dat_o = core_reg.dat;
    assign wb_ack_o = core_reg.ack;
    assign tx_byte  = core_reg.tx_out;

endmodule

// file: test/i2sts_chk_assertions.sv
/* Checker for i2sts_core: Wishbone answer timing and status coding.
   Sees the core's ports only; bound in at the foot of this file. */
`timescale 1ns/10ps
module i2sts_chk #(parameter int DW = 8) (
    // Clock and reset
    input wire logic          core_clk,
    input wire logic          reset_n,
    // Watched ports
    input wire logic          wb_cyc_i,
    input wire logic          wb_stb_i,
    input wire logic          wb_we_i,
    input wire logic [7:0]    wb_adr_i,
    input wire logic [31:0]   wb_dat_o,
    input wire logic          wb_ack_o,
    input wire logic          tx_pop,
    input wire logic [DW-1:0] tx_byte,
    input wire logic          lock_set
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire rd_ok = wb_ack_o && !wb_we_i;
    wire st_rd = rd_ok && wb_adr_i == i2sts_pkg::STAT_OFS;
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data idle");
    property p_tx_excl; st_rd |-> !(wb_dat_o[4] && wb_dat_o[3]); endproperty
    a_tx_excl: assert property (p_tx_excl)
        else $error("tx full and empty");
    property p_rx_excl; st_rd |-> !(wb_dat_o[2] && wb_dat_o[1]); endproperty
    a_rx_excl: assert property (p_rx_excl)
        else $error("rx full and empty");
    property p_ckmd; st_rd && wb_dat_o[5] |-> wb_dat_o[0]; endproperty
    a_ckmd: assert property (p_ckmd)
        else $error("clock drive without busy");
    property p_flush;
        !tx_pop ##1 lock_set && !tx_pop ##1 tx_pop
            |=> $stable(tx_byte) ##1 $stable(tx_byte);
    endproperty
    a_flush: assert property (p_flush)
        else $error("pop after lock gave data");
    property p_unmap; rd_ok && wb_adr_i > 8'h0F |-> wb_dat_o == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule
bind i2sts_core i2sts_chk #(.DW(DW)) i2sts_chk_i (.core_clk, .reset_n,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
    .tx_pop, .tx_byte, .lock_set);

// file: test/i2sts_far_master.sv
/* Outside two-wire master at the pins. Lines have pull-ups, so a
   released line reads 1. Assumes link_clk runs free. */
`timescale 1ns/10ps
module i2sts_far_master (
    // Link clock
    input wire logic link_clk,
    // Pin levels
    output logic     scl,
    output logic     sda
);
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Clock left low after START, as a stretching target would hold it
    task automatic start_cond();
        @(posedge link_clk) sda <= 1'b0;
        @(posedge link_clk) scl <= 1'b0;
    endtask
    task automatic stop_cond();
        @(posedge link_clk) scl <= 1'b1;
        @(posedge link_clk) sda <= 1'b1;
    endtask
endmodule

// file: test/test_i2sts_core.sv
/* Bench for i2sts_core: register sequences over Wishbone, engine
   pulses and an outside master on the pins. Checker bound in. */
`timescale 1ns/10ps
module test_i2sts_core;
    logic        core_clk, link_clk, reset_n, scl, sda;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i, tx_byte, rx_byte;
    logic [3:0]  wb_sel_i, sel;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [2:0]  eng;
    int          fail_count = 0;
    int          num_checks = 0;
    i2sts_core i2sts_core_i (.core_clk, .reset_n, .link_clk, .scl_in(scl),
        .sda_in(sda), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_pop(eng[0]), .tx_byte,
        .rx_push(eng[1]), .rx_byte, .lock_set(eng[2]));
    i2sts_far_master i2sts_far_master_i (.link_clk, .scl, .sda);
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial
    begin
        link_clk = 1'b0;
        #3;
        forever #80 link_clk = ~link_clk;
    end
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_sel_i <= sel;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
        wb(1'b0, a, 32'h0);
        chk($sformatf("reg_%h", a), e, rd & m);
    endtask
    task automatic pulse(input logic [2:0] v, input logic [7:0] b);
        @(posedge core_clk);
        eng     <= v;
        rx_byte <= b;
        @(posedge core_clk);
        eng     <= 3'h0;
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #200000;
        fail_count++;
        tally_and_finish();
    end
    initial
    begin
        reset_n  = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i  = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        sel      = 4'hF;
        wb_dat_i = 32'h0;
        eng      = 3'h0;
        rx_byte  = 8'h00;
        // Long enough for ten link edges as well
        repeat (10) @(posedge link_clk);
        @(posedge core_clk) reset_n <= 1'b1;
        rc(8'h04, 32'hFFFF_FFFF, 32'h0A);
        rc(8'h08, 32'h8000, 32'h0);
        for (int i = 0; i < 7; i++)
            wb(1'b1, 8'h0C, 32'h10 + i);
        rc(8'h04, 32'h3F, 32'h02);
        wb(1'b1, 8'h0C, 32'h17);
        rc(8'h04, 32'h3F, 32'h12);
        pulse(3'h1, 8'h00);
        rc(8'h04, 32'h3F, 32'h02);
        chk("tx_byte", 32'h10, {24'h0, tx_byte});
        // Lock with a pop right behind it: nothing left to pop
        @(posedge core_clk) eng <= 3'h4;
        @(posedge core_clk) eng <= 3'h1;
        @(posedge core_clk) eng <= 3'h0;
        rc(8'h04, 32'h3F, 32'h0A);
        rc(8'h08, 32'h8000, 32'h8000);
        wb(1'b1, 8'h0C, 32'h55);
        rc(8'h04, 32'h3F, 32'h0A);
        wb(1'b1, 8'h08, 32'h0);
        rc(8'h08, 32'h8000, 32'h8000);
        // Clear without the lane of the flag byte must not clear it
        sel = 4'h1;
        wb(1'b1, 8'h08, 32'h8000);
        sel = 4'hF;
        rc(8'h08, 32'h8000, 32'h8000);
        // Hardware set and software clear in one cycle: set wins
        fork
            wb(1'b1, 8'h08, 32'h8000);
            pulse(3'h4, 8'h00);
        join
        rc(8'h08, 32'h8000, 32'h8000);
        wb(1'b1, 8'h08, 32'h8000);
        rc(8'h08, 32'h8000, 32'h0);
        wb(1'b1, 8'h0C, 32'h66);
        rc(8'h04, 32'h3F, 32'h02);
        pulse(3'h1, 8'h00);
        rc(8'h04, 32'h3F, 32'h0A);
        chk("tx_byte", 32'h66, {24'h0, tx_byte});
        // Reserved bits are written back as read: zero
        wb(1'b1, 8'h04, 32'h0000_003F);
        rc(8'h04, 32'hFFFF_FFFF, 32'h0A);
        wb(1'b1, 8'h20, 32'hFFFF_FFFF);
        rc(8'h20, 32'hFFFF_FFFF, 32'h0);
        for (int i = 0; i < 8; i++)
            pulse(3'h2, 8'hA0 + 8'(i));
        rc(8'h04, 32'h3F, 32'h0C);
        for (int i = 0; i < 8; i++)
            rc(8'h0C, 32'hFF, 32'hA0 + i);
        rc(8'h04, 32'h3F, 32'h0A);
        for (int m = 1; m >= 0; m--)
        begin
            wb(1'b1, 8'h00, 32'(m) << 1);
            i2sts_far_master_i.start_cond();
            repeat (8) @(posedge link_clk);
            // Clock line is held low here, as during stretching
            rc(8'h04, 32'h3F, 32'h0B | (32'(m) << 5));
            i2sts_far_master_i.stop_cond();
            repeat (8) @(posedge link_clk);
            rc(8'h04, 32'h3F, 32'h0A);
        end
        tally_and_finish();
    end
endmodule
